// ---- rtl/tmpc_mode_pin_control.v ----
// Mode, control pin, clock out, indicator pin and chip enable logic of a packet radio.
// Assumes an APB master on clk, radio core status on clk, and host pins asynchronous.
// Overview of operation
// - With the alternate pin enable set, GPIO pin two shows the received packet CRC valid.
// - With the alternate pin enable set, GPIO pin one shows that the part is out of Idle.
// - While reset is low the part is Off and all serial registers and data are lost.
// - On reset release the part enters Idle with every register at its default.
// - A rising trigger edge starts a receive or transmit sequence chosen by a control bit.
// - A low trigger forces Idle and abandons receive or transmit.
// - A low attention input wakes the part from Hibernate or Doze to Idle.
// - The clock out has eight selectable rates, about 32.786 kHz after reset.
// - Serial transfers happen only while chip enable is low; otherwise clock and data are ignored.
// - MISO floats while chip enable is high, or is driven low when the float bit is cleared.
// - All GPIO pins leave reset as inputs with no pull-ups.
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "tmpc_regs.vh"

module tmpc_mode_pin_control (
  input wire clk,
  input wire reset_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  input wire radioSequenceTrigger,
  input wire wakeRequest_n,
  input wire seqDone,
  input wire crcValid,
  output reg hostClockOut,
  input wire chipEnable_n,
  input wire spiClk,
  input wire mosi,
  output reg misoOut,
  output reg misoOe,
  input wire [6:0] gpioIn,
  output reg [6:0] gpioOut,
  output reg [6:0] gpioOe,
  output reg [2:0] mode
);

  localparam MODE_OFF = 3'h0;
  localparam MODE_IDLE = 3'h1;
  localparam MODE_RX = 3'h2;
  localparam MODE_TX = 3'h3;
  localparam MODE_HIBERNATE = 3'h4;
  localparam MODE_DOZE = 3'h5;

  function [9:0] halfPeriod;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: halfPeriod = `TMPC_HALF_16M;
        3'h1: halfPeriod = `TMPC_HALF_8M;
        3'h2: halfPeriod = `TMPC_HALF_4M;
        3'h3: halfPeriod = `TMPC_HALF_2M;
        3'h4: halfPeriod = `TMPC_HALF_1M;
        3'h5: halfPeriod = `TMPC_HALF_62K5;
        3'h6: halfPeriod = `TMPC_HALF_32K;
        default: halfPeriod = `TMPC_HALF_16K;
      endcase
    end
  endfunction

  reg [7:0] ctrl;
  reg [6:0] gpioDir;
  reg [6:0] gpioData;
  reg [7:0] spiTx;
  reg [7:0] spiRx;
  reg crcLatched;
  reg doneFlag;

  // Two flip-flop synchronisers for asynchronous pins
  reg [11:0] syncA;
  reg [11:0] syncB;
  wire [11:0] asyncIn = {gpioIn, mosi, spiClk, chipEnable_n, wakeRequest_n, radioSequenceTrigger};
  always @(posedge clk) begin
    if (!reset_n) begin
      syncA <= `TMPC_SYNC_RESET;
      syncB <= `TMPC_SYNC_RESET;
    end else begin
      syncA <= asyncIn;
      syncB <= syncA;
    end
  end
  wire trigS = syncB[0];
  wire wakeS_n = syncB[1];
  wire ceS_n = syncB[2];
  wire sclkS = syncB[3];
  wire mosiS = syncB[4];
  wire [6:0] gpioS = syncB[11:5];

  reg trigPrev;
  reg sclkPrev;
  always @(posedge clk) begin
    if (!reset_n) begin
      trigPrev <= 1'b0;
      sclkPrev <= 1'b0;
    end else begin
      trigPrev <= trigS;
      sclkPrev <= sclkS;
    end
  end
  wire trigRise = trigS & ~trigPrev;

  // APB decode
  wire apbSetup = psel & ~penable;
  wire apbWrite = psel & penable & pwrite;
  wire addrHit = (paddr == `TMPC_OFF_CTRL) || (paddr == `TMPC_OFF_CMD) ||
    (paddr == `TMPC_OFF_STATUS) || (paddr == `TMPC_OFF_GPIO_DIR) ||
    (paddr == `TMPC_OFF_GPIO_OUT) || (paddr == `TMPC_OFF_GPIO_IN) ||
    (paddr == `TMPC_OFF_SPI_TX) || (paddr == `TMPC_OFF_SPI_RX);
  assign pready = 1'b1;
  wire [1:0] sleepCmd = (apbWrite && paddr == `TMPC_OFF_CMD) ? pwdata[1:0] : 2'h0;

  reg [31:0] next_prdata;
  always @* begin
    next_prdata = 32'h00000000;
    case (paddr)
      `TMPC_OFF_CTRL: next_prdata[7:0] = ctrl;
      `TMPC_OFF_STATUS: begin
        next_prdata[2:0] = mode;
        next_prdata[`TMPC_STAT_CRC] = crcLatched;
        next_prdata[`TMPC_STAT_DONE] = doneFlag;
      end
      `TMPC_OFF_GPIO_DIR: next_prdata[6:0] = gpioDir;
      `TMPC_OFF_GPIO_OUT: next_prdata[6:0] = gpioData;
      `TMPC_OFF_GPIO_IN: next_prdata[6:0] = gpioS;
      `TMPC_OFF_SPI_TX: next_prdata[7:0] = spiTx;
      `TMPC_OFF_SPI_RX: next_prdata[7:0] = spiRx;
      default: next_prdata = 32'h00000000;
    endcase
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      ctrl <= `TMPC_CTRL_RESET;
      gpioDir <= `TMPC_GPIO_DIR_RESET;
      gpioData <= 7'h00;
      spiTx <= 8'h00;
    end else begin
      if (apbSetup) begin
        prdata <= pwrite ? 32'h00000000 : next_prdata;
        pslverr <= ~addrHit;
      end
      if (apbWrite) begin
        case (paddr)
          `TMPC_OFF_CTRL: ctrl <= pwdata[7:0];
          `TMPC_OFF_GPIO_DIR: gpioDir <= pwdata[6:0];
          `TMPC_OFF_GPIO_OUT: gpioData <= pwdata[6:0];
          `TMPC_OFF_SPI_TX: spiTx <= pwdata[7:0];
          default: ;
        endcase
      end
    end
  end

  // Mode state machine
  reg [2:0] next_mode;
  always @* begin
    next_mode = mode;
    case (mode)
      MODE_OFF: next_mode = MODE_IDLE;
      MODE_IDLE: begin
        if (trigRise) begin
          next_mode = ctrl[`TMPC_CTRL_SEQ_TX] ? MODE_TX : MODE_RX;
        end else if (sleepCmd == `TMPC_CMD_HIBERNATE) begin
          next_mode = MODE_HIBERNATE;
        end else if (sleepCmd == `TMPC_CMD_DOZE) begin
          next_mode = MODE_DOZE;
        end
      end
      MODE_RX, MODE_TX: begin
        if (!trigS || seqDone) begin
          next_mode = MODE_IDLE;
        end
      end
      MODE_HIBERNATE, MODE_DOZE: begin
        if (!wakeS_n) begin
          next_mode = MODE_IDLE;
        end
      end
      default: next_mode = MODE_IDLE;
    endcase
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      mode <= MODE_OFF;
      crcLatched <= 1'b0;
      doneFlag <= 1'b0;
    end else begin
      mode <= next_mode;
      if (mode == MODE_IDLE && trigRise) begin
        crcLatched <= 1'b0;
        doneFlag <= 1'b0;
      end else if ((mode == MODE_RX || mode == MODE_TX) && seqDone && trigS) begin
        doneFlag <= 1'b1;
        crcLatched <= (mode == MODE_RX) & crcValid;
      end
    end
  end

  // Clock out from a 32 MHz tick
  reg [7:0] tickAcc;
  reg [9:0] clkCount;
  wire [8:0] accSum = {1'b0, tickAcc} + {1'b0, `TMPC_TICK_STEP};
  wire tick = accSum >= {1'b0, `TMPC_TICK_WRAP};
  wire [2:0] clkSel = ctrl[`TMPC_CTRL_SEL_HI:`TMPC_CTRL_SEL_LO];
  wire clkRun = (mode == MODE_IDLE) || (mode == MODE_RX) || (mode == MODE_TX) ||
    ((mode == MODE_DOZE) && ctrl[`TMPC_CTRL_DOZE_CLK] && (clkSel >= `TMPC_SEL_1M));
  always @(posedge clk) begin
    if (!reset_n) begin
      tickAcc <= 8'h00;
      clkCount <= 10'h000;
      hostClockOut <= 1'b0;
    end else begin
      tickAcc <= tick ? accSum[7:0] - `TMPC_TICK_WRAP : accSum[7:0];
      if (!clkRun) begin
        clkCount <= 10'h000;
        hostClockOut <= 1'b0;
      end else if (tick) begin
        if (clkCount >= halfPeriod(clkSel) - 10'h001) begin
          clkCount <= 10'h000;
          hostClockOut <= ~hostClockOut;
        end else begin
          clkCount <= clkCount + 10'h001;
        end
      end
    end
  end

  // Serial shifter framed by chip enable
  reg [7:0] shiftIn;
  reg [7:0] shiftOut;
  reg [2:0] bitCount;
  wire spiLive = ~ceS_n && (mode != MODE_HIBERNATE) && (mode != MODE_DOZE);
  always @(posedge clk) begin
    if (!reset_n) begin
      shiftIn <= 8'h00;
      shiftOut <= 8'h00;
      bitCount <= 3'h0;
      spiRx <= 8'h00;
    end else if (!spiLive) begin
      bitCount <= 3'h0;
      shiftOut <= spiTx;
    end else begin
      if (sclkS && !sclkPrev) begin
        shiftIn <= {shiftIn[6:0], mosiS};
        bitCount <= bitCount + 3'h1;
        if (bitCount == `TMPC_BURST_LAST) begin
          spiRx <= {shiftIn[6:0], mosiS};
        end
      end else if (!sclkS && sclkPrev) begin
        shiftOut <= (bitCount == 3'h0) ? spiTx : {shiftOut[6:0], 1'b0};
      end
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      misoOut <= 1'b0;
      misoOe <= 1'b0;
    end else begin
      misoOut <= spiLive ? shiftOut[7] : 1'b0;
      misoOe <= spiLive | ~ctrl[`TMPC_CTRL_MISO_FLOAT];
    end
  end

  // GPIO drivers with alternate functions on pins one and two
  wire outOfIdle = (mode != MODE_IDLE);
  wire altEn = ctrl[`TMPC_CTRL_ALT_EN];
  always @(posedge clk) begin
    if (!reset_n) begin
      gpioOut <= 7'h00;
      gpioOe <= 7'h00;
    end else begin
      gpioOut <= gpioData;
      gpioOe <= gpioDir;
      if (altEn) begin
        gpioOut[0] <= outOfIdle;
        gpioOe[0] <= 1'b1;
        gpioOut[1] <= crcLatched;
        gpioOe[1] <= 1'b1;
      end
    end
  end

endmodule // tmpc_mode_pin_control

// ---- rtl/tmpc_regs.vh ----
// Register offsets, field positions and reset values of the mode pin control block.
// Assumes a 32-bit APB master and a 200 MHz core clock.
`ifndef TMPC_REGS_VH
`define TMPC_REGS_VH

`define TMPC_OFF_CTRL 8'h00
`define TMPC_OFF_CMD 8'h04
`define TMPC_OFF_STATUS 8'h08
`define TMPC_OFF_GPIO_DIR 8'h0C
`define TMPC_OFF_GPIO_OUT 8'h10
`define TMPC_OFF_GPIO_IN 8'h14
`define TMPC_OFF_SPI_TX 8'h18
`define TMPC_OFF_SPI_RX 8'h1C

`define TMPC_CTRL_ALT_EN 0
`define TMPC_CTRL_MISO_FLOAT 1
`define TMPC_CTRL_SEQ_TX 2
`define TMPC_CTRL_SEL_LO 4
`define TMPC_CTRL_SEL_HI 6
`define TMPC_CTRL_DOZE_CLK 7
`define TMPC_CTRL_RESET 8'h62

`define TMPC_CMD_HIBERNATE 2'h1
`define TMPC_CMD_DOZE 2'h2
`define TMPC_STAT_CRC 4
`define TMPC_STAT_DONE 5

`define TMPC_GPIO_W 7
`define TMPC_GPIO_DIR_RESET 7'h00
// Synchroniser idle levels: chip enable and attention high, the rest low
`define TMPC_SYNC_RESET 12'h006
`define TMPC_BURST_LAST 3'h7

// Core tick at 32 MHz from 200 MHz clock: add 32 each cycle, wrap at 200
`define TMPC_TICK_STEP 8'h20
`define TMPC_TICK_WRAP 8'hC8
// Clock out half periods in 32 MHz ticks
`define TMPC_HALF_16M 10'h001
`define TMPC_HALF_8M 10'h002
`define TMPC_HALF_4M 10'h004
`define TMPC_HALF_2M 10'h008
`define TMPC_HALF_1M 10'h010
`define TMPC_HALF_62K5 10'h100
`define TMPC_HALF_32K 10'h1E8
`define TMPC_HALF_16K 10'h3D0
`define TMPC_SEL_1M 3'h4

`endif

// ---- test/tmpc_chk_assertions.sv ----
// Assertions on the mode pin control block's ports.
// Assumes binding into the block, with clk and reset_n.
`timescale 1ns/1ps
module tmpc_chk (
  input wire clk,
  input wire reset_n,
  input wire radioSequenceTrigger,
  input wire wakeRequest_n,
  input wire hostClockOut,
  input wire chipEnable_n,
  input wire misoOut,
  input wire misoOe,
  input wire [6:0] gpioOe,
  input wire [2:0] mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_reset_off: assert property (disable iff (1'b0)
    !reset_n |=> mode == 3'h0 && gpioOe == 7'h00) else $error("off");
  chk_reset_idle: assert property (disable iff (1'b0)
    !reset_n ##1 reset_n |=> mode == 3'h1) else $error("idle");
  chk_seq_start: assert property ($past(mode) == 3'h1
    && mode inside {3'h2, 3'h3} |-> $past(radioSequenceTrigger, 2)) else $error("start");
  chk_seq_abort: assert property ((!radioSequenceTrigger) [*6]
    |-> !(mode inside {3'h2, 3'h3})) else $error("abort");
  chk_wake_idle: assert property ((!wakeRequest_n) [*6]
    |-> !(mode inside {3'h4, 3'h5})) else $error("wake");
  chk_clk_stop: assert property ((mode == 3'h4) [*3]
    |-> !hostClockOut) else $error("clock");
  chk_miso_float: assert property ((chipEnable_n) [*5]
    |-> !(misoOe && misoOut)) else $error("float");
  chk_miso_drive: assert property ((!chipEnable_n && mode < 3'h4) [*5]
    |-> misoOe) else $error("drive");
endmodule // tmpc_chk
bind tmpc_mode_pin_control tmpc_chk chk (
  .clk(clk),
  .reset_n(reset_n),
  .radioSequenceTrigger(radioSequenceTrigger),
  .wakeRequest_n(wakeRequest_n),
  .hostClockOut(hostClockOut),
  .chipEnable_n(chipEnable_n),
  .misoOut(misoOut),
  .misoOe(misoOe),
  .gpioOe(gpioOe),
  .mode(mode)
);

// ---- test/tmpc_host.sv ----
// Host model driving trigger, attention and serial pins.
// Assumes the block's clk; pins change just after its rising edge.
`timescale 1ns/1ps
module tmpc_host (
  input wire clk,
  input wire misoOut,
  input wire misoOe,
  output logic radioSequenceTrigger = 1'b0,
  output logic wakeRequest_n = 1'b1,
  output logic chipEnable_n = 1'b1,
  output logic spiClk = 1'b0,
  output logic mosi = 1'b0
);
  logic lastMiso = 1'b0;
  wire miso = misoOe ? misoOut : ~lastMiso;
  always @(posedge clk) lastMiso <= miso;
  // Raised after programming, held through the sequence, then dropped
  task automatic setTrig(input logic v);
    @(posedge clk);
    radioSequenceTrigger <= v;
  endtask
  task automatic wake();
    @(posedge clk);
    wakeRequest_n <= 1'b0;
    repeat (8) @(posedge clk);
    wakeRequest_n <= 1'b1;
  endtask
  // One burst, MSB first; with en low the clock runs outside a frame
  task automatic burst(input logic en, input logic [7:0] tx, output logic [7:0] rx);
    @(posedge clk);
    chipEnable_n <= ~en;
    for (int i = 7; i >= 0; i--) begin
      mosi <= tx[i];
      repeat (8) @(posedge clk);
      rx[i] = miso;
      spiClk <= 1'b1;
      repeat (8) @(posedge clk);
      spiClk <= 1'b0;
    end
    repeat (8) @(posedge clk);
    chipEnable_n <= 1'b1;
  endtask
endmodule // tmpc_host

// ---- test/testbench.sv ----
// Self-checking bench of the mode pin control block.
// Assumes the block with its bound checker and the host model.
`timescale 1ns/1ps
`include "tmpc_regs.vh"
module testbench;
  function automatic real periodNs(input logic [2:0] s);
    case (s)
      3'h0: periodNs = 62.5;
      3'h1: periodNs = 125.0;
      3'h2: periodNs = 250.0;
      3'h3: periodNs = 500.0;
      3'h4: periodNs = 1000.0;
      3'h5: periodNs = 16000.0;
      3'h6: periodNs = 30500.0;
      default: periodNs = 61000.0;
    endcase
  endfunction
  logic clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic seqDone = 1'b0, crcValid = 1'b0, err;
  logic [7:0] paddr = 8'h00, rx;
  logic [31:0] pwdata = 32'h0, rd;
  logic [6:0] gpioIn = 7'h2A;
  logic [2:0] s;
  realtime t0;
  int n_mismatch = 0, compares = 0, cyc = 0;
  wire pready, pslverr, hostClockOut, misoOut, misoOe, radioSequenceTrigger;
  wire wakeRequest_n, chipEnable_n, spiClk, mosi;
  wire [31:0] prdata;
  wire [6:0] gpioOut, gpioOe;
  wire [2:0] mode;
  initial forever #2.5 clk = ~clk;
  tmpc_mode_pin_control dut (
    .clk(clk),
    .reset_n(reset_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pready(pready),
    .prdata(prdata),
    .pslverr(pslverr),
    .radioSequenceTrigger(radioSequenceTrigger),
    .wakeRequest_n(wakeRequest_n),
    .seqDone(seqDone),
    .crcValid(crcValid),
    .hostClockOut(hostClockOut),
    .chipEnable_n(chipEnable_n),
    .spiClk(spiClk),
    .mosi(mosi),
    .misoOut(misoOut),
    .misoOe(misoOe),
    .gpioIn(gpioIn),
    .gpioOut(gpioOut),
    .gpioOe(gpioOe),
    .mode(mode)
  );
  tmpc_host host (
    .clk(clk),
    .misoOut(misoOut),
    .misoOe(misoOe),
    .radioSequenceTrigger(radioSequenceTrigger),
    .wakeRequest_n(wakeRequest_n),
    .chipEnable_n(chipEnable_n),
    .spiClk(spiClk),
    .mosi(mosi)
  );
  task automatic check(input string n, input logic [32:0] seen, input logic [32:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdChk(input string n, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(n, rd, exp);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic done();
    @(posedge clk);
    seqDone <= 1'b1;
    @(posedge clk);
    seqDone <= 1'b0;
    wt(4);
  endtask
  task automatic conclude();
    if (n_mismatch == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_mismatch++;
      conclude();
    end
  end
  initial begin
    wt(3);
    check("off", {mode, gpioOe, misoOe}, 11'h0);
    @(posedge clk);
    reset_n <= 1'b1;
    wt(1);
    check("idle", mode, 3'h1);
    rdChk("ctrl", `TMPC_OFF_CTRL, 32'h62);
    rdChk("dir", `TMPC_OFF_GPIO_DIR, 32'h0);
    rdChk("pins", `TMPC_OFF_GPIO_IN, 32'h2A);
    gpioIn <= 7'h55;
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped", {err, rd}, 33'h100000000);
    rdChk("pins2", `TMPC_OFF_GPIO_IN, 32'h55);
    for (int i = 0; i < 8; i++) begin
      s = 3'(i + 6);
      if (i > 0)
        apb(1'b1, `TMPC_OFF_CTRL, {25'h0, s, 4'h2});
      @(posedge hostClockOut);
      @(posedge hostClockOut);
      t0 = $realtime;
      @(posedge hostClockOut);
      check("clkOut", ($realtime - t0 - periodNs(s)) ** 2 < 50.0, 1'b1);
    end
    apb(1'b1, `TMPC_OFF_GPIO_DIR, 32'h7F);
    apb(1'b1, `TMPC_OFF_GPIO_OUT, 32'h55);
    wt(2);
    check("gpio", {gpioOe, gpioOut}, 14'h3FD5);
    apb(1'b1, `TMPC_OFF_CTRL, 32'h67);
    host.setTrig(1'b1);
    wt(8);
    check("tx", {mode, gpioOe[0], gpioOut[0]}, 5'h0F);
    done();
    check("once", {mode, gpioOut[0]}, 4'h2);
    host.setTrig(1'b0);
    wt(4);
    apb(1'b1, `TMPC_OFF_CTRL, 32'h63);
    crcValid <= 1'b1;
    host.setTrig(1'b1);
    wt(8);
    check("rx", mode, 3'h2);
    done();
    check("crcPin", {gpioOe[1], gpioOut[1]}, 2'h3);
    rdChk("status", `TMPC_OFF_STATUS, 32'h31);
    host.setTrig(1'b0);
    wt(4);
    host.setTrig(1'b1);
    wt(8);
    check("rx2", mode, 3'h2);
    host.setTrig(1'b0);
    wt(8);
    check("abort", {mode, gpioOut[0]}, 4'h2);
    for (int i = 1; i < 3; i++) begin
      apb(1'b1, `TMPC_OFF_CMD, i);
      wt(4);
      check("sleep", mode, 3'h3 + i);
      host.wake();
      wt(4);
      check("wake", mode, 3'h1);
    end
    apb(1'b1, `TMPC_OFF_CTRL, 32'hC2);
    apb(1'b1, `TMPC_OFF_CMD, 32'h2);
    @(posedge hostClockOut);
    t0 = $realtime;
    @(posedge hostClockOut);
    check("dozeClk", {mode, ($realtime - t0 - 1000.0) ** 2 < 50.0}, 4'hB);
    host.wake();
    wt(4);
    check("wake2", mode, 3'h1);
    apb(1'b1, `TMPC_OFF_SPI_TX, 32'hA5);
    host.burst(1'b1, 8'h3C, rx);
    check("miso", rx, 8'hA5);
    rdChk("spiRx", `TMPC_OFF_SPI_RX, 32'h3C);
    host.burst(1'b0, 8'hC3, rx);
    rdChk("ceHigh", `TMPC_OFF_SPI_RX, 32'h3C);
    apb(1'b1, `TMPC_OFF_CTRL, 32'h61);
    wt(4);
    check("misoLow", {misoOe, misoOut}, 2'h2);
    @(posedge clk);
    reset_n <= 1'b0;
    wt(2);
    check("off2", {mode, gpioOe}, 10'h0);
    @(posedge clk);
    reset_n <= 1'b1;
    wt(2);
    rdChk("ctrl2", `TMPC_OFF_CTRL, 32'h62);
    rdChk("dir2", `TMPC_OFF_GPIO_DIR, 32'h0);
    rdChk("spiRx2", `TMPC_OFF_SPI_RX, 32'h0);
    conclude();
  end
endmodule // testbench
